// ===== pkg/rtcv_pkg.sv
// package: register map, field layout and pointer codes for the rtc value windows
`default_nettype none
package rtcv_pkg;
  // ---------------------------------------------------------------------------
  // register map (word index on the plain register port)
  // ---------------------------------------------------------------------------
  localparam logic [2:0] ADDR_CONFIG = 3'h0;
  localparam logic [2:0] ADDR_TIME_WIN = 3'h1;
  localparam logic [2:0] ADDR_ALARM_CFG = 3'h2;
  localparam logic [2:0] ADDR_ALARM_WIN = 3'h3;
  // ---------------------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------------------
  localparam int UNLOCK_BIT = 13;
  localparam int PTR_LO = 8;
  localparam int PTR_HI = 9;
  localparam logic [1:0] PTR_MINSEC = 2'h0;
  localparam logic [1:0] PTR_WDHR = 2'h1;
  localparam logic [1:0] PTR_MTHDAY = 2'h2;
  // ---------------------------------------------------------------------------
  // implemented bits of each value register and of the two control registers
  // ---------------------------------------------------------------------------
  localparam logic [15:0] MASK_WDHR = 16'h073F;
  localparam logic [15:0] MASK_MINSEC = 16'h7F7F;
  localparam logic [15:0] MASK_MTHDAY = 16'h1F3F;
  localparam logic [15:0] CONFIG_MASK = 16'h2300;
  localparam logic [15:0] ALARM_CFG_MASK = 16'h0300;
  // field positions (lsb of each digit)
  localparam int WDAY_LSB = 8;
  localparam int HRTEN_LSB = 4;
  localparam int MINTEN_LSB = 12;
  localparam int MINONE_LSB = 8;
  localparam int SECTEN_LSB = 4;
  localparam int MTHTEN_LSB = 12;
  localparam int DAYTEN_LSB = 4;
endpackage
`default_nettype wire

// ===== hdl/rtcv_value_regs.sv
// module: time and alarm value registers reached through pointer windows
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rtcv_value_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  output logic value_write_unlock,
  output logic [1:0] time_window_pointer,
  output logic [1:0] alarm_window_pointer
);
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [1:0] rtcv_ptr_dec(input logic [1:0] p);
    rtcv_ptr_dec = (p == rtcv_pkg::PTR_MINSEC) ? p : p - 2'h1;
  endfunction

  // ---------------------------------------------------------------------------
  // value registers, no reset on the digits
  // ---------------------------------------------------------------------------
  logic [15:0] time_weekday_hours;
  logic [15:0] time_minutes_seconds;
  logic [15:0] alarm_month_day;
  logic [15:0] alarm_weekday_hours;
  logic [15:0] alarm_minutes_seconds;
  logic time_win_wr;
  logic time_win_acc;
  logic alarm_win_wr;
  logic alarm_win_acc;
  logic cfg_wr;
  logic acfg_wr;

  assign time_win_wr = reg_write && (reg_addr == rtcv_pkg::ADDR_TIME_WIN);
  assign alarm_win_wr = reg_write && (reg_addr == rtcv_pkg::ADDR_ALARM_WIN);
  assign time_win_acc = (reg_write || reg_read) && (reg_addr == rtcv_pkg::ADDR_TIME_WIN);
  assign alarm_win_acc = (reg_write || reg_read) && (reg_addr == rtcv_pkg::ADDR_ALARM_WIN);
  assign cfg_wr = reg_write && (reg_addr == rtcv_pkg::ADDR_CONFIG);
  assign acfg_wr = reg_write && (reg_addr == rtcv_pkg::ADDR_ALARM_CFG);

  // digits left unreset on purpose: contents undefined until software writes
  always_ff @(posedge clk)
  begin
    if (time_win_wr && time_window_pointer == rtcv_pkg::PTR_WDHR && value_write_unlock)
      time_weekday_hours <= reg_wdata & rtcv_pkg::MASK_WDHR;
  end

  // time min/sec shares the unlock with weekday/hour; alarm min/sec stays open
  always_ff @(posedge clk)
  begin
    if (time_win_wr && time_window_pointer == rtcv_pkg::PTR_MINSEC && value_write_unlock)
      time_minutes_seconds <= reg_wdata & rtcv_pkg::MASK_MINSEC;
  end

  always_ff @(posedge clk)
  begin
    if (alarm_win_wr && value_write_unlock)
    begin
      case (alarm_window_pointer)
        rtcv_pkg::PTR_MTHDAY: alarm_month_day <= reg_wdata & rtcv_pkg::MASK_MTHDAY;
        rtcv_pkg::PTR_WDHR: alarm_weekday_hours <= reg_wdata & rtcv_pkg::MASK_WDHR;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (alarm_win_wr && alarm_window_pointer == rtcv_pkg::PTR_MINSEC)
      alarm_minutes_seconds <= reg_wdata & rtcv_pkg::MASK_MINSEC;
  end

  // ---------------------------------------------------------------------------
  // control: unlock bit and window pointers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      value_write_unlock <= 1'b0;
    else if (cfg_wr)
      value_write_unlock <= reg_wdata[rtcv_pkg::UNLOCK_BIT];
  end

  // a pointer write wins over a window access in the same cycle cannot occur: strobes hit one address
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      time_window_pointer <= rtcv_pkg::PTR_MINSEC;
    else if (cfg_wr)
      time_window_pointer <= reg_wdata[rtcv_pkg::PTR_HI:rtcv_pkg::PTR_LO];
    else if (time_win_acc)
      time_window_pointer <= rtcv_ptr_dec(time_window_pointer);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      alarm_window_pointer <= rtcv_pkg::PTR_MINSEC;
    else if (acfg_wr)
      alarm_window_pointer <= reg_wdata[rtcv_pkg::PTR_HI:rtcv_pkg::PTR_LO];
    else if (alarm_win_acc)
      alarm_window_pointer <= rtcv_ptr_dec(alarm_window_pointer);
  end

  // ---------------------------------------------------------------------------
  // read path, pointer sampled before its decrement
  // ---------------------------------------------------------------------------
  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    if (reg_read)
    begin
      case (reg_addr)
        rtcv_pkg::ADDR_CONFIG:
          next_rdata = {2'h0, value_write_unlock, 3'h0, time_window_pointer, 8'h00};
        rtcv_pkg::ADDR_ALARM_CFG:
          next_rdata = {6'h00, alarm_window_pointer, 8'h00};
        rtcv_pkg::ADDR_TIME_WIN:
        begin
          case (time_window_pointer)
            rtcv_pkg::PTR_WDHR: next_rdata = time_weekday_hours & rtcv_pkg::MASK_WDHR;
            rtcv_pkg::PTR_MINSEC: next_rdata = time_minutes_seconds & rtcv_pkg::MASK_MINSEC;
            default: next_rdata = 16'h0000;
          endcase
        end
        rtcv_pkg::ADDR_ALARM_WIN:
        begin
          case (alarm_window_pointer)
            rtcv_pkg::PTR_MTHDAY: next_rdata = alarm_month_day & rtcv_pkg::MASK_MTHDAY;
            rtcv_pkg::PTR_WDHR: next_rdata = alarm_weekday_hours & rtcv_pkg::MASK_WDHR;
            rtcv_pkg::PTR_MINSEC: next_rdata = alarm_minutes_seconds & rtcv_pkg::MASK_MINSEC;
            default: next_rdata = 16'h0000;
          endcase
        end
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= next_rdata;
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence locked_time_write_s;
    time_win_wr && time_window_pointer == rtcv_pkg::PTR_WDHR && !value_write_unlock;
  endsequence

  locked_write_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    locked_time_write_s |=> $stable(time_weekday_hours))
    else $error("locked weekday/hour write took effect");

  time_ptr_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_win_acc && time_window_pointer != rtcv_pkg::PTR_MINSEC |=>
      time_window_pointer == $past(time_window_pointer) - 2'h1)
    else $error("time pointer did not decrement");

  time_ptr_floor_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_win_acc && !cfg_wr && time_window_pointer == rtcv_pkg::PTR_MINSEC |=>
      time_window_pointer == rtcv_pkg::PTR_MINSEC)
    else $error("time pointer wrapped below zero");

  alarm_ptr_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_win_acc && alarm_window_pointer != rtcv_pkg::PTR_MINSEC |=>
      alarm_window_pointer == $past(alarm_window_pointer) - 2'h1)
    else $error("alarm pointer did not decrement");

  unlock_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_wr |=> value_write_unlock == $past(reg_wdata[rtcv_pkg::UNLOCK_BIT]))
    else $error("unlock bit not taken from bit 13");

  unused_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_read && reg_addr == rtcv_pkg::ADDR_TIME_WIN |=>
      (reg_rdata & ~rtcv_pkg::MASK_WDHR & ~rtcv_pkg::MASK_MINSEC) == 16'h0000)
    else $error("unimplemented bits read non-zero");

  minsec_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_win_wr && time_window_pointer == rtcv_pkg::PTR_MINSEC && value_write_unlock ##1 !reg_write ##1
      reg_read && reg_addr == rtcv_pkg::ADDR_TIME_WIN |=>
      reg_rdata == ($past(reg_wdata, 3) & rtcv_pkg::MASK_MINSEC))
    else $error("min/sec readback mismatch");

  alarm_mthday_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_win_wr && value_write_unlock && alarm_window_pointer == rtcv_pkg::PTR_MTHDAY |=>
      alarm_month_day == ($past(reg_wdata) & rtcv_pkg::MASK_MTHDAY))
    else $error("alarm month/day not written");

  // digit widths for the field checks
  localparam int ONES_LSB = 0;
  localparam int DIGIT_W = 4;
  localparam int WDAY_W = 3;
  localparam int HRTEN_W = 2;
  localparam int TENS_W = 3;
  localparam int MTHTEN_W = 1;
  localparam int DAYTEN_W = 2;

  sequence time_wdhr_write_s;
    time_win_wr && time_window_pointer == rtcv_pkg::PTR_WDHR && value_write_unlock;
  endsequence

  sequence time_minsec_write_s;
    time_win_wr && time_window_pointer == rtcv_pkg::PTR_MINSEC && value_write_unlock;
  endsequence

  sequence alarm_mthday_write_s;
    alarm_win_wr && alarm_window_pointer == rtcv_pkg::PTR_MTHDAY && value_write_unlock;
  endsequence

  sequence alarm_wdhr_write_s;
    alarm_win_wr && alarm_window_pointer == rtcv_pkg::PTR_WDHR && value_write_unlock;
  endsequence

  sequence alarm_minsec_write_s;
    alarm_win_wr && alarm_window_pointer == rtcv_pkg::PTR_MINSEC;
  endsequence

  wday_field_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_wdhr_write_s |=>
      time_weekday_hours[rtcv_pkg::WDAY_LSB +: WDAY_W] ==
      $past(reg_wdata[rtcv_pkg::WDAY_LSB +: WDAY_W]))
    else $error("weekday code not stored");

  hour_tens_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_wdhr_write_s |=>
      time_weekday_hours[rtcv_pkg::HRTEN_LSB +: HRTEN_W] ==
      $past(reg_wdata[rtcv_pkg::HRTEN_LSB +: HRTEN_W]))
    else $error("hour tens not stored");

  hour_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_wdhr_write_s |=>
      time_weekday_hours[ONES_LSB +: DIGIT_W] ==
      $past(reg_wdata[ONES_LSB +: DIGIT_W]))
    else $error("hour ones not stored");

  alarm_wday_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_wdhr_write_s |=>
      alarm_weekday_hours ==
      ($past(reg_wdata) & rtcv_pkg::MASK_WDHR))
    else $error("alarm weekday/hour not stored");

  min_tens_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_minsec_write_s |=>
      time_minutes_seconds[rtcv_pkg::MINTEN_LSB +: TENS_W] ==
      $past(reg_wdata[rtcv_pkg::MINTEN_LSB +: TENS_W]))
    else $error("minute tens not stored");

  min_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_minsec_write_s |=>
      time_minutes_seconds[rtcv_pkg::MINONE_LSB +: DIGIT_W] ==
      $past(reg_wdata[rtcv_pkg::MINONE_LSB +: DIGIT_W]))
    else $error("minute ones not stored");

  sec_tens_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_minsec_write_s |=>
      time_minutes_seconds[rtcv_pkg::SECTEN_LSB +: TENS_W] ==
      $past(reg_wdata[rtcv_pkg::SECTEN_LSB +: TENS_W]))
    else $error("second tens not stored");

  sec_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_minsec_write_s |=>
      time_minutes_seconds[ONES_LSB +: DIGIT_W] ==
      $past(reg_wdata[ONES_LSB +: DIGIT_W]))
    else $error("second ones not stored");

  alarm_minsec_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_minsec_write_s |=>
      alarm_minutes_seconds ==
      ($past(reg_wdata) & rtcv_pkg::MASK_MINSEC))
    else $error("alarm min/sec not stored");

  month_tens_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_mthday_write_s |=>
      alarm_month_day[rtcv_pkg::MTHTEN_LSB +: MTHTEN_W] ==
      $past(reg_wdata[rtcv_pkg::MTHTEN_LSB +: MTHTEN_W]))
    else $error("month tens not stored");

  month_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_mthday_write_s |=>
      alarm_month_day[rtcv_pkg::MINONE_LSB +: DIGIT_W] ==
      $past(reg_wdata[rtcv_pkg::MINONE_LSB +: DIGIT_W]))
    else $error("month ones not stored");

  day_tens_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_mthday_write_s |=>
      alarm_month_day[rtcv_pkg::DAYTEN_LSB +: DAYTEN_W] ==
      $past(reg_wdata[rtcv_pkg::DAYTEN_LSB +: DAYTEN_W]))
    else $error("day tens not stored");

  day_ones_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_mthday_write_s |=>
      alarm_month_day[ONES_LSB +: DIGIT_W] ==
      $past(reg_wdata[ONES_LSB +: DIGIT_W]))
    else $error("day ones not stored");

  minsec_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
    time_win_wr && time_window_pointer == rtcv_pkg::PTR_MINSEC &&
      !value_write_unlock |=>
      $stable(time_minutes_seconds))
    else $error("locked min/sec write took effect");

  mthday_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_win_wr && alarm_window_pointer == rtcv_pkg::PTR_MTHDAY &&
      !value_write_unlock |=>
      $stable(alarm_month_day))
    else $error("locked alarm month/day write took effect");

  awdhr_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_win_wr && alarm_window_pointer == rtcv_pkg::PTR_WDHR &&
      !value_write_unlock |=>
      $stable(alarm_weekday_hours))
    else $error("locked alarm weekday/hour write took effect");

  alarm_ptr_floor_a: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_win_acc && !acfg_wr &&
      alarm_window_pointer == rtcv_pkg::PTR_MINSEC |=>
      alarm_window_pointer == rtcv_pkg::PTR_MINSEC)
    else $error("alarm pointer wrapped below zero");

  time_ptr_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_wr |=>
      time_window_pointer ==
      $past(reg_wdata[rtcv_pkg::PTR_HI:rtcv_pkg::PTR_LO]))
    else $error("time pointer not loaded");

  alarm_ptr_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    acfg_wr |=>
      alarm_window_pointer ==
      $past(reg_wdata[rtcv_pkg::PTR_HI:rtcv_pkg::PTR_LO]))
    else $error("alarm pointer not loaded");

  rdata_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !reg_read |=>
      reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");

  time_ptr_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_read && reg_addr == rtcv_pkg::ADDR_TIME_WIN &&
      time_window_pointer > rtcv_pkg::PTR_WDHR |=>
      reg_rdata == 16'h0000)
    else $error("time window outside scope read non-zero");

  alarm_ptr_top_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_read && reg_addr == rtcv_pkg::ADDR_ALARM_WIN &&
      alarm_window_pointer > rtcv_pkg::PTR_MTHDAY |=>
      reg_rdata == 16'h0000)
    else $error("unimplemented alarm slot read non-zero");

  unlock_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg_wr |=>
      $stable(value_write_unlock))
    else $error("unlock bit changed without a write");

  wdhr_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_read && reg_addr == rtcv_pkg::ADDR_TIME_WIN &&
      time_window_pointer == rtcv_pkg::PTR_WDHR |=>
      reg_rdata == ($past(time_weekday_hours) & rtcv_pkg::MASK_WDHR))
    else $error("weekday/hour read mismatch");
endmodule // rtcv_value_regs
`default_nettype wire

// ===== verif/rtcv_tb.sv
// testbench: directed checks of the rtc time and alarm value windows
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [2:0] CF = rtcv_pkg::ADDR_CONFIG;
  localparam logic [2:0] TW = rtcv_pkg::ADDR_TIME_WIN;
  localparam logic [2:0] AC = rtcv_pkg::ADDR_ALARM_CFG;
  localparam logic [2:0] AW = rtcv_pkg::ADDR_ALARM_WIN;
  logic clk;
  logic reset_n;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic value_write_unlock;
  logic [1:0] time_window_pointer;
  logic [1:0] alarm_window_pointer;
  int n_errors;
  int tests_run;
  int cycles;
  // ---------------------------------------------------------------------------
  // clock, hang guard and design
  // ---------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  rtcv_value_regs uut (
    .clk(clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .value_write_unlock(value_write_unlock),
    .time_window_pointer(time_window_pointer),
    .alarm_window_pointer(alarm_window_pointer)
  );
  // ---------------------------------------------------------------------------
  // bus cycles and compares
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk2(input string name, input logic [1:0] exp, input logic [1:0] got);
    chk(name, {14'h0, exp}, {14'h0, got});
  endtask
  // a dead cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk("rdata", exp, reg_rdata);
    @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_time;
    wr(CF, 16'h2100);
    chk2("unlock", 2'h1, {1'b0, value_write_unlock});
    chk2("tptr", 2'h1, time_window_pointer);
    wr(TW, 16'hFEE3);
    chk2("tptr", 2'h0, time_window_pointer);
    wr(TW, 16'hD9D9);
    chk2("tptr", 2'h0, time_window_pointer);
    wr(CF, 16'h2100);
    rd(TW, 16'h0623);
    rd(TW, 16'h5959);
    wr(TW, 16'hA5C3);
    rd(TW, 16'h2543);
    wr(CF, 16'h0100);
    wr(TW, 16'h0111);
    wr(TW, 16'h1234);
    wr(CF, 16'h2100);
    rd(TW, 16'h0623);
    rd(TW, 16'h2543);
  endtask
  task automatic t_alarm;
    wr(CF, 16'h2000);
    wr(AC, 16'h0200);
    wr(AW, 16'hF2F9);
    chk2("aptr", 2'h1, alarm_window_pointer);
    wr(AW, 16'hFDD9);
    wr(AW, 16'hC5B7);
    chk2("aptr", 2'h0, alarm_window_pointer);
    wr(AC, 16'h0200);
    rd(AW, 16'h1239);
    rd(AW, 16'h0519);
    rd(AW, 16'h4537);
    wr(CF, 16'h0000);
    wr(AC, 16'h0200);
    wr(AW, 16'h0000);
    wr(AW, 16'h0000);
    wr(AW, 16'h0000);
    wr(AC, 16'h0200);
    rd(AW, 16'h1239);
    rd(AW, 16'h0519);
    rd(AW, 16'h0000);
  endtask
  task automatic t_reserved;
    wr(3'h5, 16'hFFFF);
    rd(3'h5, 16'h0000);
    wr(CF, 16'hFFFF);
    rd(CF, 16'h2300);
    rd(TW, 16'h0000);
    chk2("tptr", 2'h2, time_window_pointer);
    wr(AC, 16'hFFFF);
    rd(AC, 16'h0300);
    rd(AW, 16'h0000);
    chk2("aptr", 2'h2, alarm_window_pointer);
  endtask
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    chk("rst_rdata", 16'h0000, reg_rdata);
    chk2("rst_unlock", 2'h0, {1'b0, value_write_unlock});
    chk2("rst_tptr", 2'h0, time_window_pointer);
    chk2("rst_aptr", 2'h0, alarm_window_pointer);
    @(posedge clk);
    t_time();
    t_alarm();
    t_reserved();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
